// file: design/xpfs_status_bank.sv
// Rate-match and transmit phase FIFO status bank with an AHB-Lite slave.
`timescale 1ns/1ps
`include "xpfs_defs.svh"
module xpfs_status_bank #(
    parameter bit          HARD_XAUI      = 1'b1,
    parameter bit          MULTI_QUAD     = 1'b0,
    parameter int          RCFG_OUT_W     = HARD_XAUI ? `XPFS_RCFG_OUT_HARD
                                                      : `XPFS_RCFG_OUT_SOFT,
    parameter logic [23:0] RST_TIMER_CYC  = `XPFS_RST_TIMER_CYC,
    parameter logic [23:0] LOSS_TIMER_CYC = `XPFS_LOSS_TIMER_CYC,
    parameter logic [23:0] SHORT_CYC      = `XPFS_SHORT_TIMER_CYC
) (
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output      logic [31:0]                   hrdata,
    output      logic                          hreadyout,
    output      logic                          hresp,
    output      logic                          irq,
    input  wire logic [2*`XPFS_LANES-1:0]      rm_insert,
    input  wire logic [2*`XPFS_LANES-1:0]      rm_delete,
    input  wire logic [`XPFS_LANES*`XPFS_LVL_W-1:0] rm_fill_level,
    input  wire logic [`XPFS_TXPC_LANES-1:0]   txpc_overflow,
    input  wire logic [`XPFS_TXPC_LANES-1:0]   txpc_underrun,
    input  wire logic                          signal_lost,
    output      logic                          rst_timer_done,
    output      logic                          loss_detected,
    output      logic                          sim_shorten,
    input  wire logic [`XPFS_RCFG_IN_W-1:0]    reconfiguration_inbound_bus,
    output      logic [`XPFS_RCFG_IN_W-1:0]    xcvr_reconfig_ctrl,
    input  wire logic [RCFG_OUT_W-1:0]         xcvr_reconfig_status,
    output      logic [RCFG_OUT_W-1:0]         reconfig_outbound_bus
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        xpfs_pkg::xpfs_dphase_t    dp;
        logic [31:0]               hrdata;
        logic                      hreadyout;
        logic                      sim_flag;
        logic [`XPFS_IRQ_W-1:0]    irq_stat;
        logic [`XPFS_IRQ_W-1:0]    irq_mask;
        logic                      irq;
        xpfs_pkg::xpfs_tmr_state_t rst_state;
        logic [23:0]               rst_cnt;
        logic [23:0]               loss_cnt;
        logic                      loss_det;
        logic [`XPFS_RCFG_IN_W-1:0] rcfg_ctrl;
        logic [RCFG_OUT_W-1:0]     rcfg_out;
    } xpfs_bank_state_t;

    xpfs_bank_state_t s_r;
    xpfs_bank_state_t s_nxt;

    // ------------------------------------------------------------------
    // Sticky keepers for the three read-clear registers
    // ------------------------------------------------------------------
    xpfs_flag_if #(.W(4*`XPFS_LANES)) col_fl (.clk(clk), .rst_b(rst_b));
    xpfs_flag_if #(.W(2*`XPFS_LANES)) occ_fl (.clk(clk), .rst_b(rst_b));
    xpfs_flag_if #(.W(`XPFS_TXPC_LANES)) txp_fl (.clk(clk), .rst_b(rst_b));

    xpfs_sticky #(.W(4*`XPFS_LANES)) u_col (.fl(col_fl));
    xpfs_sticky #(.W(2*`XPFS_LANES)) u_occ (.fl(occ_fl));
    xpfs_sticky #(.W(`XPFS_TXPC_LANES)) u_txp (.fl(txp_fl));

    // ------------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------------
    logic [`XPFS_LANES-1:0] lane_full;
    logic [`XPFS_LANES-1:0] lane_empty;
    logic                   hard_en;

    // The soft variant has no rate-match hardware, so its fields stay zero.
    assign hard_en = HARD_XAUI;

    genvar ln;
    generate
        for (ln = 0; ln < `XPFS_LANES; ln++) begin : g_lane
            assign lane_full[ln] = hard_en &
                (rm_fill_level[ln*`XPFS_LVL_W +: `XPFS_LVL_W]
                 >= `XPFS_RM_FULL_WORDS);
            assign lane_empty[ln] = hard_en &
                (rm_fill_level[ln*`XPFS_LVL_W +: `XPFS_LVL_W]
                 <= `XPFS_RM_EMPTY_WORDS);
        end
    endgenerate

    // Insert pulses sit in the upper byte, delete pulses in the lower byte.
    assign col_fl.ev = {rm_insert & {2*`XPFS_LANES{hard_en}},
                        rm_delete & {2*`XPFS_LANES{hard_en}}};
    assign occ_fl.ev = {lane_full, lane_empty};
    assign txp_fl.ev = txpc_overflow | txpc_underrun;

    // ------------------------------------------------------------------
    // Bus address phase decode
    // ------------------------------------------------------------------
    logic       aphase;
    logic       a_hit;
    logic [7:0] a_idx;
    logic       a_rd;

    assign aphase = hsel & hready & htrans[1];
    assign a_idx  = haddr[9:2];
    assign a_hit  = (haddr[31:10] == 22'h00_0000) & (haddr[1:0] == 2'b00);
    assign a_rd   = aphase & ~hwrite & a_hit;

    // A read taken on this edge returns the pre-clear value and clears.
    assign col_fl.rd_clr = a_rd & (a_idx == `XPFS_IDX_COL_EVENTS);
    assign occ_fl.rd_clr = a_rd & (a_idx == `XPFS_IDX_OCCUPANCY);
    assign txp_fl.rd_clr = a_rd & (a_idx == `XPFS_IDX_TXPC_ERR);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic [31:0]            rd_word;
    logic [`XPFS_IRQ_W-1:0] irq_ev;
    logic [`XPFS_IRQ_W-1:0] irq_w1c;
    logic                   dp_wr;
    logic [23:0]            rst_lim;
    logic [23:0]            loss_lim;
    logic                   loss_rise;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (a_idx == `XPFS_IDX_COL_EVENTS) begin
            rd_word = {16'h0000, col_fl.flags};
        end else if (a_idx == `XPFS_IDX_OCCUPANCY) begin
            rd_word = {24'h00_0000, occ_fl.flags};
        end else if (a_idx == `XPFS_IDX_TXPC_ERR) begin
            rd_word = {29'h0000_0000, txp_fl.flags};
        end else if (a_idx == `XPFS_IDX_SIM_CTRL) begin
            rd_word = {31'h0000_0000, s_r.sim_flag};
        end else if (a_idx == `XPFS_IDX_IRQ_STATUS) begin
            rd_word = {26'h000_0000, s_r.irq_stat};
        end else if (a_idx == `XPFS_IDX_IRQ_MASK) begin
            rd_word = {26'h000_0000, s_r.irq_mask};
        end
        if (!a_hit) begin
            rd_word = 32'h0000_0000;
        end
    end

    assign dp_wr    = s_r.dp.valid & s_r.dp.wr & s_r.dp.hit;
    assign rst_lim  = s_r.sim_flag ? SHORT_CYC : RST_TIMER_CYC;
    assign loss_lim = s_r.sim_flag ? SHORT_CYC : LOSS_TIMER_CYC;

    always_comb begin
        s_nxt     = s_r;
        irq_w1c   = '0;
        loss_rise = 1'b0;

        // Address phase capture; zero wait states, always OKAY.
        s_nxt.hreadyout = 1'b1;
        s_nxt.dp.valid  = aphase;
        s_nxt.dp.wr     = hwrite;
        s_nxt.dp.hit    = a_hit;
        s_nxt.dp.idx    = a_idx;
        if (aphase && !hwrite) begin
            s_nxt.hrdata = rd_word;
        end

        // Data phase writes.
        if (dp_wr) begin
            if (s_r.dp.idx == `XPFS_IDX_SIM_CTRL) begin
                s_nxt.sim_flag = hwdata[0];
            end else if (s_r.dp.idx == `XPFS_IDX_IRQ_STATUS) begin
                irq_w1c = hwdata[`XPFS_IRQ_W-1:0];
            end else if (s_r.dp.idx == `XPFS_IDX_IRQ_MASK) begin
                s_nxt.irq_mask = hwdata[`XPFS_IRQ_W-1:0];
            end
        end

        // Reset timer: restarts whenever the shortening bit changes.
        case (s_r.rst_state)
            xpfs_pkg::XPFS_TMR_COUNT: begin
                if (s_r.rst_cnt + 24'h00_0001 >= rst_lim) begin
                    s_nxt.rst_state = xpfs_pkg::XPFS_TMR_DONE;
                end else begin
                    s_nxt.rst_cnt = s_r.rst_cnt + 24'h00_0001;
                end
            end
            xpfs_pkg::XPFS_TMR_DONE: begin
                s_nxt.rst_state = xpfs_pkg::XPFS_TMR_DONE;
            end
            default: begin
                s_nxt.rst_state = xpfs_pkg::XPFS_TMR_COUNT;
            end
        endcase
        if (s_nxt.sim_flag != s_r.sim_flag) begin
            s_nxt.rst_state = xpfs_pkg::XPFS_TMR_COUNT;
            s_nxt.rst_cnt   = 24'h00_0000;
        end

        // Loss timer: signal must stay lost for the full duration.
        if (!signal_lost) begin
            s_nxt.loss_cnt = 24'h00_0000;
            s_nxt.loss_det = 1'b0;
        end else if (!s_r.loss_det) begin
            if (s_r.loss_cnt + 24'h00_0001 >= loss_lim) begin
                s_nxt.loss_det = 1'b1;
                loss_rise      = 1'b1;
            end else begin
                s_nxt.loss_cnt = s_r.loss_cnt + 24'h00_0001;
            end
        end

        // Interrupt status; a set in the clearing cycle wins.
        irq_ev = '0;
        irq_ev[`XPFS_IRQ_INSERT] = |col_fl.ev[4*`XPFS_LANES-1:2*`XPFS_LANES];
        irq_ev[`XPFS_IRQ_DELETE] = |col_fl.ev[2*`XPFS_LANES-1:0];
        irq_ev[`XPFS_IRQ_FULL]   = |lane_full;
        irq_ev[`XPFS_IRQ_EMPTY]  = |lane_empty;
        irq_ev[`XPFS_IRQ_TXPC]   = |txp_fl.ev;
        irq_ev[`XPFS_IRQ_LOSS]   = loss_rise;
        s_nxt.irq_stat = (s_r.irq_stat & ~irq_w1c) | irq_ev;
        s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);

        // Reconfiguration: a single quad keeps the buses internal and idle.
        if (MULTI_QUAD) begin
            s_nxt.rcfg_ctrl = reconfiguration_inbound_bus;
            s_nxt.rcfg_out  = xcvr_reconfig_status;
        end else begin
            s_nxt.rcfg_ctrl = `XPFS_RCFG_IDLE;
            s_nxt.rcfg_out  = '0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_r           <= '0;
            s_r.rst_state <= xpfs_pkg::XPFS_TMR_COUNT;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hrdata                = s_r.hrdata;
    assign hreadyout             = s_r.hreadyout;
    assign hresp                 = 1'b0;
    assign irq                   = s_r.irq;
    assign rst_timer_done        = (s_r.rst_state == xpfs_pkg::XPFS_TMR_DONE);
    assign loss_detected         = s_r.loss_det;
    assign sim_shorten           = s_r.sim_flag;
    assign xcvr_reconfig_ctrl    = s_r.rcfg_ctrl;
    assign reconfig_outbound_bus = s_r.rcfg_out;

endmodule

// file: inc/xpfs_defs.svh
// Offsets, field positions, levels and timing counts of the status bank.
`ifndef XPFS_DEFS_SVH
`define XPFS_DEFS_SVH

`define XPFS_IDX_COL_EVENTS  8'h87
`define XPFS_IDX_OCCUPANCY   8'h88
`define XPFS_IDX_TXPC_ERR    8'h89
`define XPFS_IDX_SIM_CTRL    8'h8a
`define XPFS_IDX_IRQ_STATUS  8'h8b
`define XPFS_IDX_IRQ_MASK    8'h8c

`define XPFS_LANES           4
`define XPFS_TXPC_LANES      3
`define XPFS_LVL_W           5
`define XPFS_RM_FULL_WORDS   5'h14
`define XPFS_RM_EMPTY_WORDS  5'h05
`define XPFS_IRQ_W           6

`define XPFS_IRQ_INSERT      0
`define XPFS_IRQ_DELETE      1
`define XPFS_IRQ_FULL        2
`define XPFS_IRQ_EMPTY       3
`define XPFS_IRQ_TXPC        4
`define XPFS_IRQ_LOSS        5

`define XPFS_RST_TIMER_CYC   24'h00_2710
`define XPFS_LOSS_TIMER_CYC  24'h00_2710
`define XPFS_SHORT_TIMER_CYC 24'h00_0010

`define XPFS_RCFG_IN_W       4
`define XPFS_RCFG_OUT_SOFT   68
`define XPFS_RCFG_OUT_HARD   16
`define XPFS_RCFG_IDLE       4'h0

`endif

// file: inc/xpfs_pkg.sv
// Types shared by the status bank modules.
package xpfs_pkg;

    typedef enum logic [0:0] {
        XPFS_TMR_COUNT,
        XPFS_TMR_DONE
    } xpfs_tmr_state_t;

    typedef struct packed {
        logic       valid;
        logic       wr;
        logic       hit;
        logic [7:0] idx;
    } xpfs_dphase_t;

endpackage

// file: inc/xpfs_flag_if.sv
// Event, read-clear and flag bundle between the bank and a sticky keeper.
`timescale 1ns/1ps
interface xpfs_flag_if #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_b
);
    logic [W-1:0] ev;
    logic         rd_clr;
    logic [W-1:0] flags;

    modport keeper (
        input  clk,
        input  rst_b,
        input  ev,
        input  rd_clr,
        output flags
    );

    modport user (
        output ev,
        output rd_clr,
        input  flags
    );
endinterface

// file: design/xpfs_sticky.sv
// Sticky read-clear flag keeper, one flip-flop per event bit.
`timescale 1ns/1ps
module xpfs_sticky #(
    parameter int W = 8
) (
    xpfs_flag_if.keeper fl
);

    typedef struct packed {
        logic [W-1:0] flags;
    } xpfs_sticky_state_t;

    xpfs_sticky_state_t s_r;
    xpfs_sticky_state_t s_nxt;
    logic [W-1:0]       bit_nxt;

    // A new event in the clearing cycle lands after the clear and survives.
    genvar b;
    generate
        for (b = 0; b < W; b++) begin : g_bit
            assign bit_nxt[b] = (s_r.flags[b] & ~fl.rd_clr) | fl.ev[b];
        end
    endgenerate

    always_comb begin
        s_nxt       = s_r;
        s_nxt.flags = bit_nxt;
    end

    always_ff @(posedge fl.clk) begin
        if (!fl.rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fl.flags = s_r.flags;

endmodule

// file: tb/xpfs_sb_asserts.sv
// Port checker for the status bank.
`timescale 1ns/1ps
`include "xpfs_defs.svh"
module xpfs_sb_asserts #(
    parameter bit HARD_XAUI  = 1'b1,
    parameter bit MULTI_QUAD = 1'b0,
    parameter int RCFG_OUT_W = 16
) (
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [31:0]           hwdata,
    input wire logic [31:0]           hrdata,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic [7:0]            rm_insert,
    input wire logic [7:0]            rm_delete,
    input wire logic [19:0]           rm_fill_level,
    input wire logic [2:0]            txpc_overflow,
    input wire logic [2:0]            txpc_underrun,
    input wire logic                  sim_shorten,
    input wire logic [3:0]            xcvr_reconfig_ctrl,
    input wire logic [RCFG_OUT_W-1:0] reconfig_outbound_bus
);
    logic tk, rd_col, rd_occ, rd_txp, ev0, full0, emp3, txe1;
    logic sim_wr_q;
    logic sim_val_q;
    assign tk     = hsel && hreadyout && htrans[1];
    assign rd_col = tk && !hwrite && haddr[9:2] == `XPFS_IDX_COL_EVENTS;
    assign rd_occ = tk && !hwrite && haddr[9:2] == `XPFS_IDX_OCCUPANCY;
    assign rd_txp = tk && !hwrite && haddr[9:2] == `XPFS_IDX_TXPC_ERR;
    assign ev0    = rm_insert == 8'h00 && rm_delete == 8'h00;
    assign full0  = rm_fill_level[4:0] >= `XPFS_RM_FULL_WORDS;
    assign emp3   = rm_fill_level[19:15] <= `XPFS_RM_EMPTY_WORDS;
    assign txe1   = txpc_overflow[1] | txpc_underrun[1];
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sim_wr_q  <= 1'b0;
            sim_val_q <= 1'b0;
        end else begin
            sim_wr_q  <= tk && hwrite && haddr[9:2] == `XPFS_IDX_SIM_CTRL;
            sim_val_q <= sim_wr_q ? hwdata[0] : sim_val_q;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_okay; hresp == 1'b0; endproperty
    property p_ready; $past(rst_b) |-> hreadyout; endproperty
    // The soft variant must read its rate-match fields as zero.
    property p_ins;
        rd_col && $past(rm_insert[0]) |=> hrdata[8] == HARD_XAUI;
    endproperty
    property p_del;
        rd_col && $past(rm_delete[7]) |=> hrdata[7] == HARD_XAUI;
    endproperty
    property p_full;
        rd_occ && $past(full0) |=> hrdata[4] == HARD_XAUI;
    endproperty
    property p_empty;
        rd_occ && $past(emp3) |=> hrdata[3] == HARD_XAUI;
    endproperty
    property p_txpc; rd_txp && $past(txe1) |=> hrdata[1]; endproperty
    property p_clr;
        (rd_col && ev0) ##1 ev0 ##1 rd_col |=> hrdata[15:0] == 16'h0000;
    endproperty
    property p_sim; sim_wr_q |=> ##[0:1] sim_shorten == sim_val_q; endproperty
    property p_quad;
        !MULTI_QUAD |-> xcvr_reconfig_ctrl == 4'h0
            && reconfig_outbound_bus == '0;
    endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    a_ready: assert property (p_ready) else $error("hreadyout low");
    a_ins: assert property (p_ins) else $error("insert lost");
    a_del: assert property (p_del) else $error("delete lost");
    a_full: assert property (p_full) else $error("full lost");
    a_empty: assert property (p_empty) else $error("empty lost");
    a_txpc: assert property (p_txpc) else $error("txpc lost");
    a_clr: assert property (p_clr) else $error("no read clear");
    a_sim: assert property (p_sim) else $error("sim bit");
    a_quad: assert property (p_quad) else $error("reconfig out");
    c_col: cover property (rd_col ##1 hrdata[15:0] != 16'h0000);
    c_sim: cover property (sim_wr_q ##1 sim_val_q);
    c_txp: cover property (rd_txp ##1 hrdata[2:0] != 3'h0);
endmodule
bind xpfs_status_bank xpfs_sb_asserts #(
    .HARD_XAUI(HARD_XAUI),
    .MULTI_QUAD(MULTI_QUAD),
    .RCFG_OUT_W(RCFG_OUT_W)
) xpfs_sb_asserts_inst (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rm_insert(rm_insert), .rm_delete(rm_delete),
    .rm_fill_level(rm_fill_level), .txpc_overflow(txpc_overflow),
    .txpc_underrun(txpc_underrun), .sim_shorten(sim_shorten),
    .xcvr_reconfig_ctrl(xcvr_reconfig_ctrl),
    .reconfig_outbound_bus(reconfig_outbound_bus)
);

// file: tb/xpfs_rcfg_model.sv
// Behavioural reconfiguration controller beside the status bank.
`timescale 1ns/1ps
module xpfs_rcfg_model #(
    parameter int W = 16
) (
    input  wire logic         clk,
    output      logic [3:0]   to_xcvr,
    output      logic [W-1:0] status
);
    initial begin
        to_xcvr = 4'h0;
        status  = '0;
    end
    // Both buses change every cycle so a stale copy is never mistaken.
    always @(posedge clk) begin
        to_xcvr <= to_xcvr + 4'h1;
        status  <= ~status;
    end
endmodule

// file: tb/xpfs_status_bank_tb.sv
// Self-checking bench of the status bank.
`timescale 1ns/1ps
`include "xpfs_defs.svh"
`define XPFS_CMP(g, e) begin n_compared++; if ((g) !== (e)) begin \
    n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end end
module xpfs_status_bank_tb;
    localparam int          SHORT = 8;
    localparam logic [19:0] LV    = 20'h5_294A;
    logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic [1:0]  htrans = 2'h0;
    logic        hreadyout, hresp, irq, tmr_done, loss_det, sim_sh;
    logic [7:0]  ins = 8'h00, del = 8'h00;
    logic [19:0] lvl = LV;
    logic [2:0]  ovf = 3'h0, unr = 3'h0;
    logic        lost = 1'b0;
    logic [3:0]  rc_in, rc_ctrl;
    logic [15:0] rc_st, rc_out;
    logic [31:0] hrdata2, d2;
    logic [3:0]  rc_ctrl2;
    logic [67:0] rc_out2;
    int          n_errors = 0, n_compared = 0, n;
    xpfs_status_bank #(.SHORT_CYC(24'h00_0008), .RST_TIMER_CYC(24'h00_00C8),
        .LOSS_TIMER_CYC(24'h00_00C8)) xpfs_status_bank_inst (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq), .rm_insert(ins), .rm_delete(del),
        .rm_fill_level(lvl), .txpc_overflow(ovf), .txpc_underrun(unr),
        .signal_lost(lost), .rst_timer_done(tmr_done),
        .loss_detected(loss_det), .sim_shorten(sim_sh),
        .reconfiguration_inbound_bus(rc_in), .xcvr_reconfig_ctrl(rc_ctrl),
        .xcvr_reconfig_status(rc_st), .reconfig_outbound_bus(rc_out));
    xpfs_rcfg_model #(.W(16)) xpfs_rcfg_model_inst (
        .clk(clk), .to_xcvr(rc_in), .status(rc_st));
    // Soft variant spanning several quads, sharing the bus and events.
    xpfs_status_bank #(.HARD_XAUI(1'b0), .MULTI_QUAD(1'b1))
        xpfs_status_bank_soft_inst (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata2), .hreadyout(),
        .hresp(), .irq(), .rm_insert(ins), .rm_delete(del),
        .rm_fill_level(lvl), .txpc_overflow(ovf), .txpc_underrun(unr),
        .signal_lost(lost), .rst_timer_done(), .loss_detected(),
        .sim_shorten(), .reconfiguration_inbound_bus(rc_in),
        .xcvr_reconfig_ctrl(rc_ctrl2),
        .xcvr_reconfig_status({rc_in, {4{rc_st}}}),
        .reconfig_outbound_bus(rc_out2));
    initial forever #50 clk = ~clk;
    task automatic conclude;
        $display("Counts: compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Waits one edge, then more while the slave holds hreadyout low.
    task automatic wait_rdy;
        int k = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (k >= 50) begin
            n_errors++;
            conclude();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ix,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, ix, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        d = hrdata;
        d2 = hrdata2;
    endtask
    task automatic ev(input logic [7:0] i, input logic [7:0] dl,
                      input logic [19:0] lv, input logic [2:0] o, u);
        @(posedge clk);
        ins <= i;
        del <= dl;
        lvl <= lv;
        ovf <= o;
        unr <= u;
        @(posedge clk);
        ins <= 8'h00;
        del <= 8'h00;
        lvl <= LV;
        ovf <= 3'h0;
        unr <= 3'h0;
    endtask
    // Counts cycles until the chosen timer output goes high.
    task automatic cnt(input bit loss);
        n = 0;
        while ((loss ? loss_det : tmr_done) !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        if (n >= 60) begin
            n_errors++;
            conclude();
        end
    endtask
    task automatic t_reset;
        logic [7:0] ixs [6] = '{8'h87, 8'h88, 8'h89, 8'h8a, 8'h8c, 8'h90};
        `XPFS_CMP(hreadyout, 1'b1)
        foreach (ixs[k]) begin
            bus(1'b0, ixs[k], 32'h0);
            `XPFS_CMP(d, 32'h0000_0000)
        end
        `XPFS_CMP(rc_out, 16'h0000)
        `XPFS_CMP(rc_ctrl, `XPFS_RCFG_IDLE)
        `XPFS_CMP(rc_ctrl2, rc_in - 4'h1)
        `XPFS_CMP(rc_out2, {rc_in - 4'h1, {4{~rc_st}}})
        $display("test reset done");
    endtask
    task automatic t_col;
        ev(8'h80, 8'h02, LV, 3'h0, 3'h0);
        repeat (4) @(posedge clk);
        bus(1'b1, `XPFS_IDX_COL_EVENTS, 32'hFFFF_FFFF);
        ev(8'h01, 8'h80, LV, 3'h0, 3'h0);
        bus(1'b0, `XPFS_IDX_COL_EVENTS, 32'h0);
        `XPFS_CMP(d, 32'h0000_8182)
        `XPFS_CMP(d2, 32'h0000_0000)
        bus(1'b0, `XPFS_IDX_COL_EVENTS, 32'h0);
        `XPFS_CMP(d, 32'h0000_0000)
        $display("test column events done");
    endtask
    // Lanes 3..0 at 5, 6, 19 and 20 words for one cycle.
    task automatic t_occ;
        ev(8'h00, 8'h00, 20'h2_9A74, 3'h0, 3'h0);
        bus(1'b0, `XPFS_IDX_OCCUPANCY, 32'h0);
        `XPFS_CMP(d, 32'h0000_0018)
        `XPFS_CMP(d2, 32'h0000_0000)
        bus(1'b0, `XPFS_IDX_OCCUPANCY, 32'h0);
        `XPFS_CMP(d, 32'h0000_0000)
        ev(8'h00, 8'h00, LV, 3'h0, 3'h4);
        repeat (3) @(posedge clk);
        ev(8'h00, 8'h00, LV, 3'h2, 3'h0);
        bus(1'b0, `XPFS_IDX_TXPC_ERR, 32'h0);
        `XPFS_CMP(d, 32'h0000_0006)
        bus(1'b0, `XPFS_IDX_TXPC_ERR, 32'h0);
        `XPFS_CMP(d, 32'h0000_0000)
        $display("test occupancy and phase errors done");
    endtask
    task automatic t_irq;
        bus(1'b1, `XPFS_IDX_IRQ_STATUS, 32'h0000_003F);
        bus(1'b1, `XPFS_IDX_IRQ_MASK, 32'h0000_0001);
        ev(8'h04, 8'h00, LV, 3'h0, 3'h0);
        repeat (2) @(posedge clk);
        `XPFS_CMP(irq, 1'b1)
        bus(1'b1, `XPFS_IDX_IRQ_STATUS, 32'h0000_0001);
        ev(8'h00, 8'h10, LV, 3'h0, 3'h0);
        repeat (2) @(posedge clk);
        `XPFS_CMP(irq, 1'b0)
        bus(1'b0, `XPFS_IDX_IRQ_STATUS, 32'h0);
        `XPFS_CMP(d, 32'h0000_0002)
        bus(1'b1, `XPFS_IDX_IRQ_STATUS, 32'h0000_003F);
        $display("test interrupt done");
    endtask
    task automatic t_sim;
        bus(1'b1, `XPFS_IDX_SIM_CTRL, 32'h0000_0001);
        cnt(1'b0);
        `XPFS_CMP(n >= SHORT - 3 && n <= SHORT + 3, 1'b1)
        `XPFS_CMP(sim_sh, 1'b1)
        lost <= 1'b1;
        cnt(1'b1);
        `XPFS_CMP(n >= SHORT - 3 && n <= SHORT + 3, 1'b1)
        bus(1'b0, `XPFS_IDX_IRQ_STATUS, 32'h0);
        `XPFS_CMP(d[5], 1'b1)
        lost <= 1'b0;
        repeat (2) @(posedge clk);
        `XPFS_CMP(loss_det, 1'b0)
        $display("test timers done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_col();
        t_occ();
        t_irq();
        t_sim();
        conclude();
    end
endmodule
